//--- design/fdc_regs_pkg.sv
// Package for the floppy controller register decode block.
// Assumes an 8-bit host I/O bus sampled synchronously to sys_clk_i.
package fdc_regs_pkg;

	// ****************************************
	// Register offsets (A2..A0)
	// ****************************************
	localparam logic [2:0] OFS_DISK_STATUS_A = 3'h0;
	localparam logic [2:0] OFS_DISK_STATUS_B = 3'h1;
	localparam logic [2:0] OFS_DRIVE_OUTPUT_CONTROL = 3'h2;
	localparam logic [2:0] OFS_TAPE_DRIVE_CONFIG = 3'h3;
	localparam logic [2:0] OFS_MAIN_STATUS = 3'h4;
	localparam logic [2:0] OFS_COMMAND_DATA = 3'h5;
	localparam logic [2:0] OFS_BUS_FLOAT = 3'h6;
	localparam logic [2:0] OFS_DIGITAL_INPUT = 3'h7;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int STA_HEAD_DIR = 0;
	localparam int STA_WPROT_N = 1;
	localparam int STA_INDEX_N = 2;
	localparam int STA_SIDE = 3;
	localparam int STA_TRACK_ZERO_IN_N = 4;
	localparam int STA_STEP_INV = 5;
	localparam int STA_IRQ = 7;
	localparam int STB_MOTOR0 = 0;
	localparam int STB_MOTOR1 = 1;
	localparam int STB_WRITE_GATE_OUT = 2;
	localparam int STB_RD_PAR = 3;
	localparam int STB_WR_PAR = 4;
	localparam int STB_DSEL0 = 5;
	localparam int CFG_DMA_LSB = 4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] DOC_RESET = 8'h00;
	localparam logic [7:0] TDC_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h02;
	localparam logic [7:0] BASE_LOW_RESET = 8'hF0;
	localparam logic [7:0] BASE_HIGH_RESET = 8'h03;
	localparam logic [3:0] IRQ_SEL_RESET = 4'h6;
	localparam logic [1:0] DMA_SEL_RESET = 2'h2;
	localparam logic [7:0] STB_RESERVED_ONES = 8'hC0;
	localparam int SYNC_STAGES = 2;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic head_dir;
		logic side_select_out;
		logic step;
		logic motor0_out;
		logic motor1_out;
		logic write_gate_out;
		logic write_data;
	} drive_outs_t;

	typedef struct packed {
		logic write_protect;
		logic index;
		logic track_zero_in;
		logic read_data;
		logic fdc_irq;
	} drive_ins_t;

endpackage

//--- design/fdc_sync_bit.sv
// Two-stage synchroniser for one level input.
// Assumes the input may change at any time relative to sys_clk_i.
`timescale 1ns/100ps
module fdc_sync_bit (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Level in and out
	input wire logic async_i,
	output logic sync_o
);
	logic meta_q;
	logic sync_q;

	// First stage feeds only the second
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule

//--- design/fdc_register_decode_status.sv
// Host register decode and drive status registers of the floppy controller.
// Assumes a synchronous 8-bit host I/O strobe bus and active-high drive levels.
`timescale 1ns/100ps
module fdc_register_decode_status (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Host I/O bus
	input wire logic [15:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic io_rdata_oe_o,
	// Base and routing configuration
	input wire logic cfg_wr_i,
	input wire logic [1:0] cfg_sel_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [15:0] base_addr_o,
	output logic [3:0] irq_line_o,
	output logic [1:0] dma_channel_o,
	// Mode and engine side
	input wire logic second_mode_i,
	input wire logic [7:0] main_status_i,
	input wire logic [7:0] command_data_i,
	input wire logic [7:0] digital_input_i,
	output logic command_data_wr_o,
	output logic command_data_rd_o,
	output logic [7:0] drive_output_control_o,
	output logic [7:0] tape_drive_config_o,
	output logic [7:0] rate_select_o,
	output logic [7:0] rate_config_o,
	output logic soft_reset_o,
	// Disk interface
	input wire fdc_regs_pkg::drive_outs_t drive_outs_i,
	input wire fdc_regs_pkg::drive_ins_t drive_ins_i,
	output logic [3:0] drive_select_o
);

	// ****************************************
	// Decode
	// ****************************************
	logic hit;
	logic [2:0] ofs;
	logic rd_hit;
	logic wr_hit;

	// Eight-byte window aligned to the base; low three base bits ignored
	assign hit = (io_addr_i[15:3] == base_addr_o[15:3]);
	assign ofs = io_addr_i[2:0];
	assign rd_hit = hit && io_rd_i;
	assign wr_hit = hit && io_wr_i;

	// One strobe at one offset; shared by every single-offset decode
	function automatic logic strobe_at(input logic req, input logic [2:0] at,
		input logic [2:0] want);
		strobe_at = req && (at == want);
	endfunction

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [7:0] base_low_q;
	logic [7:0] base_high_q;
	logic [3:0] irq_sel_q;
	logic [1:0] dma_sel_q;

	// Select 0/1 base bytes, 2 interrupt line, 3 DMA channel
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			base_low_q <= fdc_regs_pkg::BASE_LOW_RESET;
			base_high_q <= fdc_regs_pkg::BASE_HIGH_RESET;
			irq_sel_q <= fdc_regs_pkg::IRQ_SEL_RESET;
			dma_sel_q <= fdc_regs_pkg::DMA_SEL_RESET;
		end else if (cfg_wr_i) begin
			case (cfg_sel_i)
				2'h0: base_low_q <= cfg_wdata_i;
				2'h1: base_high_q <= cfg_wdata_i;
				2'h2: begin
					if (irq_legal(cfg_wdata_i[3:0])) begin
						irq_sel_q <= cfg_wdata_i[3:0];
					end
				end
				2'h3: begin
					// Channels 1..3 only; other codes keep the old choice
					if (cfg_wdata_i[1:0] != 2'h0) begin
						dma_sel_q <= cfg_wdata_i[1:0];
					end
				end
				default: ;
			endcase
		end
	end

	// Legal interrupt lines: 3-7, 9-12, 15
	function automatic logic irq_legal(input logic [3:0] line);
		irq_legal = (line >= 4'h3 && line <= 4'h7) || (line >= 4'h9 && line <= 4'hC) ||
			(line == 4'hF);
	endfunction

	assign base_addr_o = {base_high_q, base_low_q};
	assign irq_line_o = irq_sel_q;
	assign dma_channel_o = dma_sel_q;

	// ****************************************
	// Writable control registers
	// ****************************************
	logic [7:0] doc_q;
	logic [7:0] tdc_q;
	logic [7:0] rate_q;
	logic [7:0] ccfg_q;
	logic srst_q;

	// Drive control; hardware reset only, a software reset leaves it alone
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			doc_q <= fdc_regs_pkg::DOC_RESET;
		end else if (strobe_at(wr_hit, ofs, fdc_regs_pkg::OFS_DRIVE_OUTPUT_CONTROL)) begin
			doc_q <= io_wdata_i;
		end
	end

	// Tape drive configuration byte, kept across a software reset
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tdc_q <= fdc_regs_pkg::TDC_RESET;
		end else if (strobe_at(wr_hit, ofs, fdc_regs_pkg::OFS_TAPE_DRIVE_CONFIG)) begin
			tdc_q <= io_wdata_i;
		end
	end

	// Rate select shares offset four with the main status read
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rate_q <= fdc_regs_pkg::RATE_RESET;
		end else if (strobe_at(wr_hit, ofs, fdc_regs_pkg::OFS_MAIN_STATUS)) begin
			rate_q <= io_wdata_i;
		end
	end

	// Rate config shares offset seven with the digital input read
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ccfg_q <= fdc_regs_pkg::RATE_RESET;
		end else if (strobe_at(wr_hit, ofs, fdc_regs_pkg::OFS_DIGITAL_INPUT)) begin
			ccfg_q <= io_wdata_i;
		end
	end

	// Self-clearing software reset from bit 7 of the rate select write
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			srst_q <= 1'b0;
		end else begin
			srst_q <= strobe_at(wr_hit, ofs, fdc_regs_pkg::OFS_MAIN_STATUS) && io_wdata_i[7];
		end
	end

	assign drive_output_control_o = doc_q;
	assign tape_drive_config_o = tdc_q;
	assign rate_select_o = rate_q;
	assign rate_config_o = ccfg_q;
	// Bit 2 low holds the engine in reset
	assign soft_reset_o = srst_q || !doc_q[2];
	assign command_data_wr_o = strobe_at(wr_hit, ofs, fdc_regs_pkg::OFS_COMMAND_DATA);
	assign command_data_rd_o = strobe_at(rd_hit, ofs, fdc_regs_pkg::OFS_COMMAND_DATA);

	// Exactly one select line per code, so two drives never answer together
	function automatic logic [3:0] one_hot_drive(input logic [1:0] sel);
		case (sel)
			2'h0: one_hot_drive = 4'h1;
			2'h1: one_hot_drive = 4'h2;
			2'h2: one_hot_drive = 4'h4;
			default: one_hot_drive = 4'h8;
		endcase
	endfunction

	// One-hot drive select from the two select bits
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			drive_select_o <= 4'h0;
		end else begin
			drive_select_o <= one_hot_drive(doc_q[1:0]);
		end
	end

	// ****************************************
	// Synchronised disk signals
	// ****************************************
	localparam int NSYNC = 12;
	logic [NSYNC-1:0] raw_vec;
	logic [NSYNC-1:0] sync_vec;

	assign raw_vec = {drive_outs_i, drive_ins_i};

	// Every disk signal passes a synchroniser before use
	generate
		for (genvar i = 0; i < NSYNC; i++) begin : g_sync
			fdc_sync_bit u_sync (
				.sys_clk_i(sys_clk_i),
				.reset_n_i(reset_n_i),
				.async_i(raw_vec[i]),
				.sync_o(sync_vec[i])
			);
		end
	endgenerate

	fdc_regs_pkg::drive_outs_t outs_s;
	fdc_regs_pkg::drive_ins_t ins_s;
	assign {outs_s, ins_s} = sync_vec;

	// ****************************************
	// Parity toggles
	// ****************************************
	logic rd_prev_q;
	logic wr_prev_q;
	logic rd_par_q;
	logic wr_par_q;

	// Edge detect on the synchronised copies, never the first stage
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
			rd_par_q <= 1'b0;
			wr_par_q <= 1'b0;
		end else begin
			rd_prev_q <= ins_s.read_data;
			wr_prev_q <= outs_s.write_data;
			if (rd_prev_q && !ins_s.read_data) begin
				rd_par_q <= !rd_par_q;
			end
			if (wr_prev_q && !outs_s.write_data) begin
				wr_par_q <= !wr_par_q;
			end
		end
	end

	// ****************************************
	// Status bytes
	// ****************************************
	logic [7:0] sta_d;
	logic [7:0] stb_d;
	logic [7:0] sta_q;
	logic [7:0] stb_q;

	// Compose status A from synchronised levels
	always_comb begin
		sta_d = 8'h00;
		sta_d[fdc_regs_pkg::STA_HEAD_DIR] = outs_s.head_dir;
		sta_d[fdc_regs_pkg::STA_WPROT_N] = !ins_s.write_protect;
		sta_d[fdc_regs_pkg::STA_INDEX_N] = !ins_s.index;
		sta_d[fdc_regs_pkg::STA_SIDE] = outs_s.side_select_out;
		sta_d[fdc_regs_pkg::STA_TRACK_ZERO_IN_N] = !ins_s.track_zero_in;
		sta_d[fdc_regs_pkg::STA_STEP_INV] = !outs_s.step;
		sta_d[fdc_regs_pkg::STA_IRQ] = ins_s.fdc_irq;
	end

	// Compose status B; top two bits fixed high
	always_comb begin
		stb_d = fdc_regs_pkg::STB_RESERVED_ONES;
		stb_d[fdc_regs_pkg::STB_MOTOR0] = outs_s.motor0_out;
		stb_d[fdc_regs_pkg::STB_MOTOR1] = outs_s.motor1_out;
		stb_d[fdc_regs_pkg::STB_WRITE_GATE_OUT] = outs_s.write_gate_out;
		stb_d[fdc_regs_pkg::STB_RD_PAR] = rd_par_q;
		stb_d[fdc_regs_pkg::STB_WR_PAR] = wr_par_q;
		stb_d[fdc_regs_pkg::STB_DSEL0] = doc_q[0];
	end

	// Registered so a read sees one stable byte
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sta_q <= 8'h00;
			stb_q <= fdc_regs_pkg::STB_RESERVED_ONES;
		end else begin
			sta_q <= sta_d;
			stb_q <= stb_d;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	logic [7:0] rdata_d;
	logic rd_oe_d;

	// Offset six and status reads in AT mode leave the bus floating
	always_comb begin
		rdata_d = 8'h00;
		rd_oe_d = rd_hit;
		case (ofs)
			fdc_regs_pkg::OFS_DISK_STATUS_A: begin
				rdata_d = sta_q;
				rd_oe_d = rd_hit && second_mode_i;
			end
			fdc_regs_pkg::OFS_DISK_STATUS_B: begin
				rdata_d = stb_q;
				rd_oe_d = rd_hit && second_mode_i;
			end
			fdc_regs_pkg::OFS_DRIVE_OUTPUT_CONTROL: rdata_d = doc_q;
			fdc_regs_pkg::OFS_TAPE_DRIVE_CONFIG: rdata_d = tdc_q;
			fdc_regs_pkg::OFS_MAIN_STATUS: rdata_d = main_status_i;
			fdc_regs_pkg::OFS_COMMAND_DATA: rdata_d = command_data_i;
			fdc_regs_pkg::OFS_BUS_FLOAT: rd_oe_d = 1'b0;
			fdc_regs_pkg::OFS_DIGITAL_INPUT: rdata_d = digital_input_i;
			default: rd_oe_d = 1'b0;
		endcase
	end

	// Data from flip-flops, one cycle after the read strobe
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			io_rdata_o <= 8'h00;
			io_rdata_oe_o <= 1'b0;
		end else begin
			io_rdata_o <= rd_oe_d ? rdata_d : 8'h00;
			io_rdata_oe_o <= rd_oe_d;
		end
	end

endmodule

//--- tb/fdc_regs_chk_sva.sv
// Checker for the register decode block: decode, float and write paths.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module fdc_regs_chk (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Host bus
	input wire logic [15:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic [7:0] io_rdata_o,
	input wire logic io_rdata_oe_o,
	// Configuration and engine
	input wire logic [15:0] base_addr_o,
	input wire logic [3:0] irq_line_o,
	input wire logic [1:0] dma_channel_o,
	input wire logic second_mode_i,
	input wire logic [7:0] main_status_i,
	// Registers
	input wire logic [7:0] drive_output_control_o,
	input wire logic [3:0] drive_select_o,
	input wire logic [7:0] rate_config_o
);
	// ****************
	// Decode helpers
	// ****************
	logic hit;
	logic [2:0] ofs;
	// Window match on the upper thirteen bits only
	assign hit = io_addr_i[15:3] == base_addr_o[15:3];
	assign ofs = io_addr_i[2:0];
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	chk_read_drives_bus: assert property (io_rd_i && hit && ofs != 3'h6 &&
		(ofs > 3'h1 || second_mode_i) |=> io_rdata_oe_o) else $error("read not answered");
	chk_offset_six_float: assert property (io_rd_i && hit && ofs == 3'h6
		|=> !io_rdata_oe_o) else $error("offset six drove bus");
	chk_at_mode_float: assert property (io_rd_i && hit && ofs < 3'h2 && !second_mode_i
		|=> !io_rdata_oe_o) else $error("status drove bus in AT mode");
	chk_oe_needs_read: assert property (!(io_rd_i && hit) |=> !io_rdata_oe_o)
		else $error("bus driven without read");
	chk_main_status_read: assert property (io_rd_i && hit && ofs == 3'h4
		|=> io_rdata_o == $past(main_status_i)) else $error("main status wrong");
	chk_status_b_ones: assert property (io_rd_i && hit && ofs == 3'h1 && second_mode_i
		|=> io_rdata_o[7:6] == 2'b11) else $error("status B top bits");
	chk_rate_cfg_write: assert property (io_wr_i && hit && ofs == 3'h7
		|=> rate_config_o == $past(io_wdata_i)) else $error("rate config not loaded");
	chk_drive_select_map: assert property (io_wr_i && hit && ofs == 3'h2
		|=> drive_output_control_o == $past(io_wdata_i)
		##1 drive_select_o == 4'h1 << $past(io_wdata_i[1:0], 2)) else $error("drive select");
	chk_irq_line_legal: assert property (irq_line_o inside {[4'h3:4'h7], [4'h9:4'hC], 4'hF})
		else $error("illegal irq line");
	chk_dma_legal: assert property (dma_channel_o != 2'h0) else $error("dma channel 0");
endmodule
bind fdc_register_decode_status fdc_regs_chk fdc_regs_chk_inst (.sys_clk_i, .reset_n_i,
	.io_addr_i, .io_rd_i, .io_wr_i, .io_wdata_i, .io_rdata_o, .io_rdata_oe_o, .base_addr_o,
	.irq_line_o, .dma_channel_o, .second_mode_i, .main_status_i, .drive_output_control_o,
	.drive_select_o, .rate_config_o);

//--- tb/isa_host_model.sv
// Host processor model: single-cycle I/O reads and writes.
// Assumes the device answers a read one cycle after the strobe edge.
`timescale 1ns/100ps
module isa_host_model (
	// Clock
	input wire logic sys_clk_i,
	// Host bus
	output logic [15:0] io_addr_o,
	output logic io_rd_o,
	output logic io_wr_o,
	output logic [7:0] io_wdata_o,
	input wire logic [7:0] io_rdata_i,
	input wire logic io_rdata_oe_i
);
	// Idle bus at time zero
	initial begin
		io_addr_o = 16'h0000;
		io_rd_o = 1'b0;
		io_wr_o = 1'b0;
		io_wdata_o = 8'h00;
	end
	// Released lines are scrambled so stale values never look valid
	task automatic io_write(input logic [15:0] a, input logic [7:0] v);
		@(negedge sys_clk_i);
		io_addr_o = a;
		io_wdata_o = v;
		io_wr_o = 1'b1;
		@(negedge sys_clk_i);
		io_wr_o = 1'b0;
		io_addr_o = ~a;
		io_wdata_o = ~v;
	endtask
	// Read answer taken half a cycle after the strobe edge
	task automatic io_read(input logic [15:0] a, output logic [7:0] v, output logic oe);
		@(negedge sys_clk_i);
		io_addr_o = a;
		io_rd_o = 1'b1;
		@(negedge sys_clk_i);
		io_rd_o = 1'b0;
		io_addr_o = ~a;
		v = io_rdata_i;
		oe = io_rdata_oe_i;
	endtask
endmodule

//--- tb/tb_fdc_register_decode_status.sv
// Testbench for the floppy register decode and status block.
// Assumes the host model drives the I/O bus; all else is driven here.
`timescale 1ns/100ps
module tb_fdc_register_decode_status;
	logic sys_clk_i, reset_n_i, io_rd, io_wr, io_oe, cfg_wr, second_mode, oe;
	logic srst, cmd_rd_p, cmd_wr_p;
	logic [15:0] io_addr, base_addr, base;
	logic [7:0] io_wdata, io_rdata, cfg_wdata, main_status, cmd, dir, doc, tdc, rsel, rcfg, d;
	logic [3:0] irq_line, dsel;
	logic [1:0] cfg_sel, dma_ch;
	fdc_regs_pkg::drive_outs_t outs;
	fdc_regs_pkg::drive_ins_t ins;
	int fail_count, tests_run;
	int srst_cnt, cmd_rd_cnt, cmd_wr_cnt, srst_base;
	fdc_register_decode_status fdc_register_decode_status_inst (.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i), .io_addr_i(io_addr), .io_rd_i(io_rd), .io_wr_i(io_wr),
		.io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .io_rdata_oe_o(io_oe), .cfg_wr_i(cfg_wr),
		.cfg_sel_i(cfg_sel), .cfg_wdata_i(cfg_wdata), .base_addr_o(base_addr),
		.irq_line_o(irq_line), .dma_channel_o(dma_ch), .second_mode_i(second_mode),
		.main_status_i(main_status), .command_data_i(cmd), .digital_input_i(dir),
		.command_data_wr_o(cmd_wr_p), .command_data_rd_o(cmd_rd_p),
		.drive_output_control_o(doc), .tape_drive_config_o(tdc), .rate_select_o(rsel),
		.rate_config_o(rcfg), .soft_reset_o(srst),
		.drive_outs_i(outs), .drive_ins_i(ins), .drive_select_o(dsel));
	isa_host_model isa_host_model_inst (.sys_clk_i(sys_clk_i), .io_addr_o(io_addr),
		.io_rd_o(io_rd), .io_wr_o(io_wr), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata),
		.io_rdata_oe_i(io_oe));
	// Free-running clock
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// Strobe counters; values read here are those launched by the previous edge
	always @(posedge sys_clk_i) begin
		if (srst)
			srst_cnt++;
		if (cmd_rd_p)
			cmd_rd_cnt++;
		if (cmd_wr_p)
			cmd_wr_cnt++;
	end
	// Hang guard, far beyond the hundred or so cycles needed
	initial begin
		#200000;
		fail_count++;
		results();
	end
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic exp_oe);
		isa_host_model_inst.io_read(a, d, oe);
		chk({7'h0, oe}, {7'h0, exp_oe});
		// Data must read zero whenever the bus is left floating
		chk(d, exp);
	endtask
	task automatic wr(input logic [2:0] o, input logic [7:0] v);
		isa_host_model_inst.io_write(base + {13'h0, o}, v);
	endtask
	task automatic cfg(input logic [1:0] s, input logic [7:0] v);
		@(negedge sys_clk_i);
		cfg_sel = s;
		cfg_wdata = v;
		cfg_wr = 1'b1;
		@(negedge sys_clk_i);
		cfg_wr = 1'b0;
	endtask
	// Two sync stages plus compose register, with margin
	task automatic settle();
		repeat (5) @(negedge sys_clk_i);
	endtask
	// ****************
	// Test sequence
	// ****************
	initial begin
		{reset_n_i, cfg_wr, cfg_sel, cfg_wdata} = '0;
		{second_mode, main_status, cmd, dir} = {1'b1, 8'h80, 8'h5A, 8'h7E};
		outs = '0;
		ins = '0;
		base = 16'h03F0;
		fail_count = 0;
		tests_run = 0;
		repeat (5) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		reset_n_i = 1'b1;
		@(negedge sys_clk_i);
		chk(base_addr[7:0], fdc_regs_pkg::BASE_LOW_RESET);
		chk(base_addr[15:8], fdc_regs_pkg::BASE_HIGH_RESET);
		chk({6'h0, dma_ch}, 8'h02);
		chk({4'h0, irq_line}, {4'h0, fdc_regs_pkg::IRQ_SEL_RESET});
		chk({4'h0, dsel}, 8'h01);
		chk(rsel, fdc_regs_pkg::RATE_RESET);
		chk({7'h0, srst}, 8'h01);
		$display("test reset done");
		wr(3'h2, 8'h05);
		chk(doc, 8'h05);
		chk({7'h0, srst}, 8'h00);
		rd(base + 16'h2, 8'h05, 1'b1);
		chk({4'h0, dsel}, 8'h02);
		wr(3'h3, 8'h03);
		chk(tdc, 8'h03);
		rd(base + 16'h3, 8'h03, 1'b1);
		wr(3'h4, 8'h01);
		chk(rsel, 8'h01);
		rd(base + 16'h4, 8'h80, 1'b1);
		rd(base + 16'h6, 8'h00, 1'b0);
		wr(3'h7, 8'h03);
		chk(rcfg, 8'h03);
		rd(base + 16'h7, 8'h7E, 1'b1);
		rd(base + 16'h5, 8'h5A, 1'b1);
		chk(8'(cmd_rd_cnt), 8'h01);
		wr(3'h5, 8'hA5);
		chk(8'(cmd_wr_cnt), 8'h01);
		$display("test map done");
		settle();
		rd(base, 8'h36, 1'b1);
		outs = 7'b1110000;
		ins = 5'b11101;
		settle();
		rd(base, 8'h89, 1'b1);
		$display("test status a done");
		rd(base + 16'h1, 8'hE0, 1'b1);
		outs.motor0_out = 1'b1;
		outs.motor1_out = 1'b1;
		outs.write_gate_out = 1'b1;
		// Three read pulses and one write pulse, so both parities end odd
		for (int i = 0; i < 3; i++) begin
			ins.read_data = 1'b1;
			outs.write_data = (i < 1);
			settle();
			ins.read_data = 1'b0;
			outs.write_data = 1'b0;
			settle();
		end
		srst_base = srst_cnt;
		wr(3'h4, 8'h81);
		settle();
		chk(8'(srst_cnt - srst_base), 8'h01);
		rd(base + 16'h1, 8'hFF, 1'b1);
		// Hardware reset mid-run; pin levels are left as they stand
		reset_n_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		settle();
		chk(doc, fdc_regs_pkg::DOC_RESET);
		chk({4'h0, dsel}, 8'h01);
		chk(rsel, fdc_regs_pkg::RATE_RESET);
		rd(base + 16'h1, 8'hC7, 1'b1);
		$display("test status b done");
		second_mode = 1'b0;
		rd(base, 8'h00, 1'b0);
		rd(base + 16'h1, 8'h00, 1'b0);
		second_mode = 1'b1;
		$display("test at mode done");
		cfg(2'h0, 8'h70);
		chk(base_addr[7:0], 8'h70);
		rd(16'h03F4, 8'h00, 1'b0);
		base = 16'h0370;
		rd(base + 16'h4, 8'h80, 1'b1);
		cfg(2'h1, 8'h02);
		chk(base_addr[15:8], 8'h02);
		rd(16'h0374, 8'h00, 1'b0);
		base = 16'h0270;
		rd(base + 16'h7, 8'h7E, 1'b1);
		cfg(2'h2, 8'h08);
		chk({4'h0, irq_line}, 8'h06);
		cfg(2'h2, 8'h0F);
		chk({4'h0, irq_line}, 8'h0F);
		cfg(2'h3, 8'h00);
		chk({6'h0, dma_ch}, 8'h02);
		cfg(2'h3, 8'h03);
		chk({6'h0, dma_ch}, 8'h03);
		$display("test relocate done");
		results();
	end
endmodule
